// File: design/cfl_flag_bank.sv
// Purpose: Sticky event flags, set by hardware and cleared by software
// Assumes: Synchronous active-low reset
// Notes:   A set in the clearing cycle wins so no event is lost
module cfl_flag_bank import cfl_pkg::*; #(
   parameter int N = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   cfl_flag_if.bank fif
);
   for (genvar i = 0; i < N; i++) begin : g_flag
      logic flag_r;
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            flag_r <= 1'b0;
         end else if (fif.set[i]) begin
            flag_r <= 1'b1;
         end else if (fif.clr[i]) begin
            flag_r <= 1'b0;
         end
      end
      assign fif.flag[i] = flag_r;
   end
endmodule // cfl_flag_bank

// File: design/cfl_flag_if.sv
// Purpose: Set, clear and flag vectors between the control logic and the flag bank
// Assumes: One bit per flag
// Notes:   None
interface cfl_flag_if import cfl_pkg::*;;
   // Nets, so each flag bit may be driven from its own generate branch
   wire cfl_flags_t set;
   wire cfl_flags_t clr;
   wire cfl_flags_t flag;
   modport bank (input set, input clr, output flag);
   modport ctl  (output set, output clr, input flag);
endinterface

// File: design/cfl_pkg.sv
// Purpose: Types shared by the clock flag block
// Assumes: Two flags, ready and clock security
// Notes:   Numbers live in cfl_regs.svh
package cfl_pkg;
   typedef logic [1:0] cfl_flags_t;
   typedef enum logic [0:0] {CFL_EV_RDY, CFL_EV_CSS} cfl_event_t;
endpackage

// File: design/cfl_regs.svh
// Purpose: Register map, field positions, reset values and timing counts of the clock flag block
// Assumes: 32-bit APB word registers at byte offsets, mclk at 25 MHz
// Notes:   Definitions only
// Behaviour
// - Fast internal oscillator ready flag sets when ready arrives with its enable set.
// - Writing 1 to the ready clear bit drops the ready flag to 0.
// - Clock security flag sets when the external fast oscillator clock fails.
// - Writing 1 to the security clear bit returns the security flag to 0.
// - Security flag reads 1 while a failure interrupt is pending, otherwise 0.
`ifndef CFL_REGS_SVH
`define CFL_REGS_SVH

`define CFL_ADDR_W          12
`define CFL_CTRL_OFF        12'h000
`define CFL_STAT_OFF        12'h004
`define CFL_CLR_OFF         12'h008
`define CFL_MASK_OFF        12'h00C

`define CFL_RDY_BIT         0
`define CFL_CSS_BIT         1
`define CFL_CTRL_RDYEN_BIT  0
`define CFL_CTRL_CSSEN_BIT  1

`define CFL_CTRL_RST        2'h0
`define CFL_MASK_RST        2'h3

`define CFL_MCLK_PERIOD_NS  40
`define CFL_CSS_TIMEOUT_NS  640
`define CFL_CSS_TIMEOUT_CYC ((`CFL_CSS_TIMEOUT_NS + `CFL_MCLK_PERIOD_NS - 1) / `CFL_MCLK_PERIOD_NS)

`endif

// File: design/cfl_top.sv
// Purpose: Ready and clock security flags with APB access and one interrupt line
// Assumes: Inputs synchronous to mclk; external oscillator clock arrives sampled
// Notes:   Status read clears the bits it returned; clear register is write-1-to-clear
//
// The address map and the APB slave port were chosen for this implementation.
`include "cfl_regs.svh"

module cfl_top import cfl_pkg::*; #(
   parameter int TIMEOUT_CYC = `CFL_CSS_TIMEOUT_CYC
) (
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   input  wire logic [`CFL_ADDR_W-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  fast_internal_osc_ready,
   input  wire logic                  external_fast_osc_clock,
   output logic                       clk_irq
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] TMO = CW'(TIMEOUT_CYC);
   localparam logic [CW-1:0] TMO_M1 = CW'(TIMEOUT_CYC - 1);

   cfl_flag_if fif ();

   cfl_flags_t ctrl_r;
   cfl_flags_t mask_r;
   logic       pready_r;
   logic       pslverr_r;
   logic       irq_r;
   logic [31:0] prdata_r;
   logic       rdy_q_r;
   logic       ext_q_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // APB phase decode; every access takes two access cycles
   wire acc_w  = psel & penable & ~pready_r;
   wire done_w = psel & penable & pready_r;

   wire hit_ctrl = (paddr == `CFL_CTRL_OFF);
   wire hit_stat = (paddr == `CFL_STAT_OFF);
   wire hit_clr  = (paddr == `CFL_CLR_OFF);
   wire hit_mask = (paddr == `CFL_MASK_OFF);
   wire mapped_w = hit_ctrl | hit_stat | hit_clr | hit_mask;

   wire wr_ctrl  = done_w & pwrite & hit_ctrl;
   wire wr_clr   = done_w & pwrite & hit_clr;
   wire wr_mask  = done_w & pwrite & hit_mask;
   wire rd_stat  = done_w & ~pwrite & hit_stat;

   wire cfl_flags_t rdata_sel =
      hit_ctrl ? ctrl_r :
      hit_stat ? fif.flag :
      hit_mask ? mask_r : 2'h0;

   // Oscillator ready edge, only while its interrupt enable is set
   wire rdy_rise = fast_internal_osc_ready & ~rdy_q_r;
   wire rdy_en   = ctrl_r[`CFL_CTRL_RDYEN_BIT];
   wire css_en   = ctrl_r[`CFL_CTRL_CSSEN_BIT];

   // Failure detector: no edge on the external clock for the timeout window
   wire toggled  = external_fast_osc_clock ^ ext_q_r;
   wire css_fail = css_en & ~toggled & (cnt_r == TMO_M1);

   assign cnt_nxt = (!css_en || toggled) ? '0 :
                    (cnt_r == TMO)       ? cnt_r : cnt_r + CW'(1);

   assign fif.set[`CFL_RDY_BIT] = rdy_rise & rdy_en;
   assign fif.set[`CFL_CSS_BIT] = css_fail;
   // Read-clear only touches bits already returned, so a late event survives
   assign fif.clr = (rd_stat ? prdata_r[1:0] : 2'h0) |
                    (wr_clr ? pwdata[1:0] : 2'h0);

   cfl_flag_bank #(.N(2)) u_bank (
      .mclk (mclk),
      .rstn (rstn),
      .fif  (fif)
   );

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= acc_w;
         pslverr_r <= acc_w & ~mapped_w;
         prdata_r  <= (acc_w & ~pwrite) ? {30'h0, rdata_sel} : 32'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl_r <= `CFL_CTRL_RST;
         mask_r <= `CFL_MASK_RST;
      end else begin
         if (wr_ctrl) ctrl_r <= pwdata[1:0];
         if (wr_mask) mask_r <= pwdata[1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdy_q_r <= 1'b0;
         ext_q_r <= 1'b0;
         cnt_r   <= '0;
      end else begin
         rdy_q_r <= fast_internal_osc_ready;
         ext_q_r <= external_fast_osc_clock;
         cnt_r   <= cnt_nxt;
      end
   end

   // One cycle behind the flags, so the line is glitch free
   always_ff @(posedge mclk) begin
      if (!rstn) irq_r <= 1'b0;
      else       irq_r <= |(fif.flag & mask_r);
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign clk_irq = irq_r;

   rdy_set_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (fast_internal_osc_ready && !rdy_q_r && rdy_en) |=> fif.flag[`CFL_RDY_BIT])
      else $error("ready flag not set after ready edge");

   rdy_gate_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (!fif.flag[`CFL_RDY_BIT] && !rdy_en) |=> !fif.flag[`CFL_RDY_BIT])
      else $error("ready flag set while disabled");

   rdy_clear_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (wr_clr && pwdata[`CFL_RDY_BIT] && !fif.set[`CFL_RDY_BIT]) |=> !fif.flag[`CFL_RDY_BIT])
      else $error("ready flag not cleared by write one");

   css_detect_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (css_en && !toggled && cnt_r == TMO_M1) |=> fif.flag[`CFL_CSS_BIT])
      else $error("clock failure not flagged");

   css_clear_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (wr_clr && pwdata[`CFL_CSS_BIT] && !css_fail) |=> !fif.flag[`CFL_CSS_BIT])
      else $error("security flag not cleared by write one");

   css_hold_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (fif.flag[`CFL_CSS_BIT] && !fif.clr[`CFL_CSS_BIT]) |=> fif.flag[`CFL_CSS_BIT])
      else $error("security flag dropped without clear");

   css_read_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (acc_w && !pwrite && hit_stat) |=> (prdata[`CFL_CSS_BIT] == $past(fif.flag[`CFL_CSS_BIT])))
      else $error("status read does not show security flag");

   irq_level_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      ##1 (clk_irq == $past(|(fif.flag & mask_r))))
      else $error("interrupt line does not follow flags");

   ready_pulse_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   wait_state_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && !pready) |=> pready)
      else $error("access not answered after one wait state");

   err_ready_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      pslverr |-> pready)
      else $error("slave error outside the answer cycle");

   rdata_idle_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      !pready |-> (prdata == 32'h0))
      else $error("read data not zero outside the answer cycle");

   ctrl_write_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && pready && pwrite && paddr == `CFL_CTRL_OFF)
      |=> (ctrl_r == $past(pwdata[1:0])))
      else $error("control write did not land");

   mask_write_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && pready && pwrite && paddr == `CFL_MASK_OFF)
      |=> (mask_r == $past(pwdata[1:0])))
      else $error("mask write did not land");

   css_gate_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (!fif.flag[`CFL_CSS_BIT] && !css_en) |=> !fif.flag[`CFL_CSS_BIT])
      else $error("security flag set while monitor off");

   rdy_hold_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (fif.flag[`CFL_RDY_BIT] && !fif.clr[`CFL_RDY_BIT]) |=> fif.flag[`CFL_RDY_BIT])
      else $error("ready flag dropped without clear");

   rdy_read_clear_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && pready && !pwrite && paddr == `CFL_STAT_OFF &&
       prdata[`CFL_RDY_BIT] && !fif.set[`CFL_RDY_BIT]) |=> !fif.flag[`CFL_RDY_BIT])
      else $error("status read did not clear ready flag");

   css_read_clear_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && pready && !pwrite && paddr == `CFL_STAT_OFF &&
       prdata[`CFL_CSS_BIT] && !fif.set[`CFL_CSS_BIT]) |=> !fif.flag[`CFL_CSS_BIT])
      else $error("status read did not clear security flag");

   irq_high_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      ((fif.flag & mask_r) != 2'h0) |=> clk_irq)
      else $error("interrupt line low with unmasked flag");

   irq_low_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      ((fif.flag & mask_r) == 2'h0) |=> !clk_irq)
      else $error("interrupt line high with no unmasked flag");

   rdy_read_a: assert property (
      @(posedge mclk) disable iff (!rstn)
      (psel && penable && !pready && !pwrite && paddr == `CFL_STAT_OFF)
      |=> (prdata[`CFL_RDY_BIT] == $past(fif.flag[`CFL_RDY_BIT])))
      else $error("status read does not show ready flag");
endmodule // cfl_top

// File: sim/cfl_top_tb.sv
// Purpose: Self-checking bench for the clock flag block
// Assumes: TIMEOUT_CYC shortened to 4 so failures show within a few cycles
// Notes:   External clock toggles every cycle unless a failure is staged
`include "cfl_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module cfl_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TO = 4;
   logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, clk_irq;
   logic        fosc = 0, ext_clk = 0, ext_run = 1;
   int          error_cnt = 0, cmp_count = 0, cyc_n = 0;

   cfl_top #(.TIMEOUT_CYC(TO)) uut (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fast_internal_osc_ready(fosc),
      .external_fast_osc_clock(ext_clk), .clk_irq(clk_irq));

   always #20 mclk = ~mclk;
   always @(posedge mclk) if (ext_run) ext_clk <= ~ext_clk;

   // Hang guard, well above the fewer than two hundred cycles the tests need
   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Looks between edges, where the registered line has settled
   task automatic irq_is(input logic x);
      @(negedge mclk);
      `CHK(clk_irq, x)
      @(posedge mclk);
   endtask

   // Request held until pready is sampled high; released right after that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1, a, d, r, e);
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, 1'b0)
   endtask

   task automatic t_reset();
      chk_rd(`CFL_CTRL_OFF, 32'h0);
      chk_rd(`CFL_MASK_OFF, 32'h3);
      chk_rd(`CFL_STAT_OFF, 32'h0);
      chk_rd(`CFL_CLR_OFF, 32'h0);
      irq_is(1'b0);
   endtask

   task automatic t_ready();
      fosc <= 1'b1;
      cyc(4);
      chk_rd(`CFL_STAT_OFF, 32'h0);
      fosc <= 1'b0;
      wr(`CFL_CTRL_OFF, 32'h1);
      fosc <= 1'b1;
      cyc(4);
      irq_is(1'b1);
      wr(`CFL_CLR_OFF, 32'h1);
      cyc(3);
      irq_is(1'b0);
      chk_rd(`CFL_STAT_OFF, 32'h0);
      fosc <= 1'b0;
      cyc(1);
      fosc <= 1'b1;
      cyc(4);
      chk_rd(`CFL_STAT_OFF, 32'h1);
      fosc <= 1'b0;
   endtask

   task automatic t_css();
      wr(`CFL_CTRL_OFF, 32'h2);
      cyc(10);
      chk_rd(`CFL_STAT_OFF, 32'h0);
      ext_run <= 1'b0;
      cyc(TO + 4);
      chk_rd(`CFL_STAT_OFF, 32'h2);
      cyc(3);
      irq_is(1'b0);
      ext_run <= 1'b1;
      cyc(4);
      ext_run <= 1'b0;
      cyc(TO + 4);
      irq_is(1'b1);
      wr(`CFL_CLR_OFF, 32'h2);
      cyc(3);
      irq_is(1'b0);
      chk_rd(`CFL_STAT_OFF, 32'h0);
      ext_run <= 1'b1;
   endtask

   // Masked flag stays pending but never reaches the interrupt line
   task automatic t_mask();
      logic [31:0] r;
      logic        e;
      wr(`CFL_MASK_OFF, 32'h0);
      cyc(4);
      ext_run <= 1'b0;
      cyc(TO + 4);
      irq_is(1'b0);
      chk_rd(`CFL_STAT_OFF, 32'h2);
      wr(`CFL_MASK_OFF, 32'h3);
      ext_run <= 1'b1;
      apb(1'b0, 12'h010, 32'h0, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0)
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1;
      t_reset();
      t_ready();
      t_css();
      t_mask();
      print_verdict();
   end
endmodule // cfl_top_tb
